// >>> verilog/spisd_top.v
// Contract
// - Set done flag at byte end; clear by flags read then data access.
// - While done flag set, data writes ignored until flags register read.
// - Data write during shifting sets write collision; flags-then-data access clears.
// - Byte completing while done flag set sets overrun; flags read clears.
// - Master with select low sets mode fault; flags read then control write clears.
// - Output disable blocks data output; otherwise driven only when enabled.
// - Soft select manage uses internal level instead of select pin.
// - Internal select level 0 means selected, 1 means deselected.
// - Master starts a byte when software writes the data register.
// - Completed byte copied to read buffer unless done flag still set; data reads return buffer only.
// - Data write loads the shift register directly, no transmit buffer.
// - Reset clears the flags register; data contents left undefined.
// - Interrupt enable raises one request on done, fault or overrun.
// - Mode fault clears peripheral enable and master select in hardware.
`timescale 1ns/1ps
`include "spisd_map.vh"
module spisd_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  input  wire        mosi_in,
  output wire        mosi_out,
  output reg         mosi_oe,
  input  wire        miso_in,
  output wire        miso_out,
  output reg         miso_oe,
  input  wire        ss_n_in,
  output reg         irq
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  reg  [7:0]  control_reg;
  reg         output_disable;
  reg         soft_select_manage;
  reg         internal_select_level;
  reg         transfer_done_flag;
  reg         write_collision_flag;
  reg         overrun_flag;
  reg         mode_fault_flag;
  reg         csr_seen;
  reg         mode_fault_flag_seen;
  reg  [7:0]  data_buffer_reg;
  reg  [7:0]  shift_reg;
  reg         rx_bit;
  reg  [4:0]  edge_cnt;
  reg         busy;
  reg  [6:0]  div_cnt;
  reg         sck_d;
  reg  [3:0]  ev_stat;
  reg  [3:0]  ev_mask;
  reg  [11:0] aw_addr;
  reg  [7:0]  w_data;
  reg         w_lane0;
  wire [3:0]  pins_s;
  wire        sck_s;
  wire        mosi_s;
  wire        miso_s;
  wire        ss_s;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  spisd_sync #(
    .W       (4),
    .RST_VAL (`SPISD_SYNC_RST)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({sck_in, mosi_in, miso_in, ss_n_in}),
    .dout    (pins_s)
  );
  assign sck_s  = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_s   = pins_s[0];

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  wire       wr_fire  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire       rd_fire  = s_axi_arvalid & s_axi_arready;
  wire       wr_ok    = (aw_addr[11:10] == 2'b00);
  wire       rd_ok    = (s_axi_araddr[11:10] == 2'b00);
  wire [7:0] wr_idx   = aw_addr[9:2];
  wire [7:0] rd_idx   = s_axi_araddr[9:2];
  wire       wr_map   = wr_ok & ((wr_idx == `SPISD_IDX_DATA) | (wr_idx == `SPISD_IDX_CTRL) |
                        (wr_idx == `SPISD_IDX_CSR) | (wr_idx == `SPISD_IDX_EVSTAT) |
                        (wr_idx == `SPISD_IDX_EVMASK));
  wire       rd_map   = rd_ok & ((rd_idx == `SPISD_IDX_DATA) | (rd_idx == `SPISD_IDX_CTRL) |
                        (rd_idx == `SPISD_IDX_CSR) | (rd_idx == `SPISD_IDX_EVSTAT) |
                        (rd_idx == `SPISD_IDX_EVMASK));
  wire       wr_go    = wr_fire & wr_ok & w_lane0;
  wire       dr_wr    = wr_go & (wr_idx == `SPISD_IDX_DATA);
  wire       ctrl_wr  = wr_go & (wr_idx == `SPISD_IDX_CTRL);
  wire       csr_wr   = wr_go & (wr_idx == `SPISD_IDX_CSR);
  wire       mask_wr  = wr_go & (wr_idx == `SPISD_IDX_EVMASK);
  wire       dr_rd    = rd_fire & rd_ok & (rd_idx == `SPISD_IDX_DATA);
  wire       csr_rd   = rd_fire & rd_ok & (rd_idx == `SPISD_IDX_CSR);
  wire       stat_rd  = rd_fire & rd_ok & (rd_idx == `SPISD_IDX_EVSTAT);

  // ----------------------------------------------------------
  // Transfer control terms
  // ----------------------------------------------------------
  wire       pe       = control_reg[`SPISD_CTRL_PE];
  wire       master_select     = control_reg[`SPISD_CTRL_MASTER_SELECT];
  wire       cpol     = control_reg[`SPISD_CTRL_CPOL];
  wire       cpha     = control_reg[`SPISD_CTRL_CPHA];
  wire       ss_int   = soft_select_manage ? internal_select_level : ss_s;
  wire       is_mst   = pe & master_select;
  wire       fault    = is_mst & ~ss_int;
  wire       wr_block = transfer_done_flag & ~csr_seen;
  wire       collide  = dr_wr & busy;
  wire       load     = dr_wr & ~wr_block & ~busy & pe & ~fault;
  reg  [6:0] half_m1;

  // Half-period of the master clock; unlisted codes take the slowest
  always @* begin
    case ({control_reg[`SPISD_CTRL_SPR1], control_reg[`SPISD_CTRL_SPR0],
           control_reg[`SPISD_CTRL_SPR2]})
      3'b001:  half_m1 = 7'h01;
      3'b000:  half_m1 = 7'h03;
      3'b010:  half_m1 = 7'h07;
      3'b101:  half_m1 = 7'h0f;
      3'b100:  half_m1 = 7'h1f;
      default: half_m1 = 7'h3f;
    endcase
  end

  // Edge events: master divider or synchronised slave clock
  wire       tick_m   = is_mst & busy & ~fault & (div_cnt == half_m1);
  wire       slv_act  = pe & ~master_select & ~ss_int;
  wire       tick_s   = slv_act & (sck_s ^ sck_d);
  wire       tick     = tick_m | tick_s;
  wire [4:0] edge_num = edge_cnt + 5'd1;
  wire       capture  = edge_num[0] ^ cpha;
  wire       din      = master_select ? miso_s : mosi_s;
  wire       last     = tick & (edge_num == `SPISD_BYTE_EDGES);
  reg  [7:0] next_shift;

  // Shift path: CPHA 0 latches then shifts, CPHA 1 shifts on capture
  always @* begin
    next_shift = shift_reg;
    if (cpha) begin
      if (capture)
        next_shift = {shift_reg[6:0], din};
    end else if (!capture) begin
      next_shift = {shift_reg[6:0], rx_bit};
    end
  end

  // Flag events, sets always beat clears
  wire       done_set = last & ~transfer_done_flag;
  wire       ovr_set  = last & transfer_done_flag;
  wire       seq_clr  = csr_seen & (dr_wr | dr_rd);
  wire [3:0] ev_set;
  assign ev_set[`SPISD_EV_DONE] = done_set;
  assign ev_set[`SPISD_EV_WRITE_COLLISION_FLAG] = collide;
  assign ev_set[`SPISD_EV_OVR]  = ovr_set;
  assign ev_set[`SPISD_EV_MODE_FAULT_FLAG] = fault;

  // ----------------------------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPISD_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SPISD_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_addr       <= 12'h000;
      w_data        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
      end
      // Response only once both halves are held
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `SPISD_RESP_OKAY : `SPISD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= rd_map ? `SPISD_RESP_OKAY : `SPISD_RESP_SLVERR;
        s_axi_rdata   <= 32'h0000_0000;
        if (rd_ok) begin
          case (rd_idx)
            `SPISD_IDX_DATA:   s_axi_rdata[7:0] <= data_buffer_reg;
            `SPISD_IDX_CTRL:   s_axi_rdata[7:0] <= control_reg;
            `SPISD_IDX_CSR:    s_axi_rdata[7:0] <= {transfer_done_flag,
                                 write_collision_flag, overrun_flag, mode_fault_flag,
                                 1'b0, output_disable, soft_select_manage,
                                 internal_select_level};
            `SPISD_IDX_EVSTAT: s_axi_rdata[3:0] <= ev_stat;
            `SPISD_IDX_EVMASK: s_axi_rdata[3:0] <= ev_mask;
            default:           s_axi_rdata      <= 32'h0000_0000;
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // Control, flags and clearing sequences
  // ----------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      control_reg           <= `SPISD_CTRL_RST;
      output_disable        <= 1'b0;
      soft_select_manage    <= 1'b0;
      internal_select_level <= 1'b0;
      transfer_done_flag    <= 1'b0;
      write_collision_flag  <= 1'b0;
      overrun_flag          <= 1'b0;
      mode_fault_flag       <= 1'b0;
      csr_seen              <= 1'b0;
      mode_fault_flag_seen             <= 1'b0;
      ev_stat               <= `SPISD_EV_RST;
      ev_mask               <= `SPISD_EV_RST;
    end else begin
      if (ctrl_wr)
        control_reg <= w_data;
      // Fault drops enable and master even against a write
      if (fault) begin
        control_reg[`SPISD_CTRL_PE]   <= 1'b0;
        control_reg[`SPISD_CTRL_MASTER_SELECT] <= 1'b0;
      end
      // Bit 3 is not stored, so it reads zero whatever is written
      if (csr_wr) begin
        output_disable        <= w_data[`SPISD_CSR_SOD];
        soft_select_manage    <= w_data[`SPISD_CSR_SSM];
        internal_select_level <= w_data[`SPISD_CSR_SSI];
      end
      transfer_done_flag   <= done_set | (transfer_done_flag & ~seq_clr);
      write_collision_flag <= collide | (write_collision_flag & ~seq_clr);
      overrun_flag         <= ovr_set | (overrun_flag & ~csr_rd);
      mode_fault_flag      <= fault | (mode_fault_flag & ~(ctrl_wr & mode_fault_flag_seen));
      // Flags read remembered until the done flag sets or data is touched
      if (csr_rd)
        csr_seen <= 1'b1;
      else if (done_set || seq_clr)
        csr_seen <= 1'b0;
      if (csr_rd && mode_fault_flag)
        mode_fault_flag_seen <= 1'b1;
      else if (ctrl_wr || fault)
        mode_fault_flag_seen <= 1'b0;
      ev_stat <= (stat_rd ? `SPISD_EV_RST : ev_stat) | ev_set;
      if (mask_wr)
        ev_mask <= w_data[3:0];
    end
  end

  // ----------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy     <= 1'b0;
      edge_cnt <= 5'd0;
      div_cnt  <= 7'd0;
      rx_bit   <= 1'b0;
      sck_d    <= 1'b0;
      sck_out  <= 1'b0;
    end else begin
      sck_d <= sck_s;
      if (load) begin
        busy     <= master_select;
        edge_cnt <= 5'd0;
        div_cnt  <= 7'd0;
        sck_out  <= cpol;
      end else if (fault || (!is_mst && !slv_act)) begin
        // Abort: fault, disable, or slave deselected mid-byte
        busy     <= 1'b0;
        edge_cnt <= 5'd0;
        sck_out  <= cpol;
      end else begin
        if (is_mst && busy)
          div_cnt <= tick_m ? 7'd0 : div_cnt + 7'd1;
        else
          sck_out <= cpol;
        if (tick_m)
          sck_out <= ~sck_out;
        if (tick) begin
          busy     <= ~last;
          edge_cnt <= last ? 5'd0 : edge_num;
          if (capture && !cpha)
            rx_bit <= din;
        end
      end
    end
  end

  // Shift register and read buffer; no reset, contents undefined
  always @(posedge aclk) begin
    if (load)
      shift_reg <= w_data;
    else if (tick && !fault)
      shift_reg <= next_shift;
    if (done_set)
      data_buffer_reg <= next_shift;
  end

  // ----------------------------------------------------------
  // Pin drivers and interrupt
  // ----------------------------------------------------------
  assign mosi_out = shift_reg[7];
  assign miso_out = shift_reg[7];

  // Enables registered one cycle late; fault gates the master enables ahead of the register
  always @(posedge aclk) begin
    if (!aresetn) begin
      sck_oe  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      irq     <= 1'b0;
    end else begin
      sck_oe  <= is_mst & ~fault;
      mosi_oe <= is_mst & ~fault & ~output_disable;
      miso_oe <= slv_act & ~output_disable;
      irq     <= (control_reg[`SPISD_CTRL_IE] &
                  (transfer_done_flag | overrun_flag | mode_fault_flag)) |
                 (|(ev_stat & ev_mask));
    end
  end
endmodule

// >>> verilog/spisd_map.vh
`ifndef SPISD_MAP_VH
`define SPISD_MAP_VH
// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SPISD_IDX_DATA     8'h21
`define SPISD_IDX_CTRL     8'h22
`define SPISD_IDX_CSR      8'h23
`define SPISD_IDX_EVSTAT   8'h24
`define SPISD_IDX_EVMASK   8'h25
// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define SPISD_CTRL_IE      7
`define SPISD_CTRL_PE      6
`define SPISD_CTRL_SPR2    5
`define SPISD_CTRL_MASTER_SELECT    4
`define SPISD_CTRL_CPOL    3
`define SPISD_CTRL_CPHA    2
`define SPISD_CTRL_SPR1    1
`define SPISD_CTRL_SPR0    0
// ------------------------------------------------------------
// Control/flags register fields
// ------------------------------------------------------------
`define SPISD_CSR_DONE     7
`define SPISD_CSR_WRITE_COLLISION_FLAG     6
`define SPISD_CSR_OVR      5
`define SPISD_CSR_MODE_FAULT_FLAG     4
`define SPISD_CSR_SOD      2
`define SPISD_CSR_SSM      1
`define SPISD_CSR_SSI      0
// ------------------------------------------------------------
// Event status / mask bit positions
// ------------------------------------------------------------
`define SPISD_EV_DONE      0
`define SPISD_EV_WRITE_COLLISION_FLAG      1
`define SPISD_EV_OVR       2
`define SPISD_EV_MODE_FAULT_FLAG      3
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define SPISD_CTRL_RST     8'h00
`define SPISD_CSR_RST      8'h00
`define SPISD_EV_RST       4'h0
`define SPISD_SYNC_RST     4'h1
`define SPISD_BYTE_EDGES   5'd16
`define SPISD_RESP_OKAY    2'b00
`define SPISD_RESP_SLVERR  2'b10
`endif

// >>> verilog/spisd_sync.v
`timescale 1ns/1ps
`include "spisd_map.vh"
module spisd_sync #(
  parameter       W       = 4,
  parameter [3:0] RST_VAL = `SPISD_SYNC_RST
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  // ----------------------------------------------------------
  // Two-stage synchroniser, one pair of flops per bit
  // ----------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      // First stage is read only by the second
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta   <= RST_VAL[i];
          stable <= RST_VAL[i];
        end else begin
          meta   <= din[i];
          stable <= meta;
        end
      end
      assign dout[i] = stable;
    end
  endgenerate
endmodule

// >>> tb/spisd_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------
// Port checker of the serial status block
// ----------------------------------------------
module spisd_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        sck_oe,
  input wire        mosi_oe,
  input wire        miso_oe,
  input wire        ss_n_in,
  input wire        irq
);
  // One domain, quiet while reset is low
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Master driving its clock while the select pin is low
  sequence pin_low_s;
    (sck_oe && !ss_n_in) [*3];
  endsequence
  // Limitation: software select with a low pin would trip this
  property master_drops_p;
    pin_low_s |-> ##[1:8] !sck_oe;
  endproperty
  reset_quiet_a : assert property (
    $past(aresetn) == 1'b0 |-> !irq && !sck_oe && !mosi_oe && !miso_oe)
    else $error("outputs active right after reset");
  one_output_a : assert property (!(mosi_oe && miso_oe))
    else $error("both data outputs driven");
  slave_no_sck_a : assert property (miso_oe |-> !sck_oe)
    else $error("slave output with clock output");
  mode_fault_a : assert property (master_drops_p)
    else $error("master kept driving after select fault");
  rdata_byte_a : assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  resp_code_a : assert property (
    s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
    else $error("bad write response code");
  bvalid_hold_a : assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a : assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
endmodule
bind spisd_top spisd_monitor i_mon (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sck_oe, .mosi_oe,
  .miso_oe, .ss_n_in, .irq);

// >>> tb/spisd_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------
// Far device: slave to our master, else master
// ----------------------------------------------
module spisd_partner (
  input  wire       aclk,
  input  wire       sck_out,
  input  wire       sck_oe,
  input  wire       mosi_out,
  input  wire       miso_out,
  output logic      sck_in,
  output logic      mosi_in,
  output logic      ss_n_in,
  output wire       miso_in
);
  logic [7:0] tx_sr = 8'h00;
  logic [7:0] rx_sr = 8'h00;
  // Idle pins; link clock stands low between frames
  initial begin
    sck_in = 1'b0;
    mosi_in = 1'b0;
    ss_n_in = 1'b1;
  end
  // Slave side, mode 0: capture on rise, next bit on fall
  always @(posedge sck_out) if (sck_oe) rx_sr <= {rx_sr[6:0], mosi_out};
  always @(negedge sck_out) if (sck_oe) tx_sr <= {tx_sr[6:0], ~tx_sr[0]};
  // Released line shows the inverse, never a stale copy
  assign miso_in = sck_oe ? tx_sr[7] : ~tx_sr[7];
  task automatic load(input [7:0] b);
    tx_sr = b;
  endtask
  task automatic pin(input logic v);
    ss_n_in <= v;
  endtask
  // Master side: 160 ns link period, MSB first
  task automatic send(input [7:0] b, input logic sel, output logic [7:0] r);
    int i;
    begin
      ss_n_in <= ~sel;
      for (i = 7; i >= 0; i--) begin
        mosi_in <= b[i];
        repeat (8) @(posedge aclk);
        r[i] = miso_out;
        sck_in <= 1'b1;
        repeat (8) @(posedge aclk);
        sck_in <= 1'b0;
      end
      repeat (8) @(posedge aclk);
      ss_n_in <= 1'b1;
      mosi_in <= ~b[0];
      repeat (8) @(posedge aclk);
    end
  endtask
endmodule

// >>> tb/spi_status_and_data_path_tb.sv
`timescale 1ns/1ps
`include "spisd_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
// ----------------------------------------------
// Bench: register bus master and far device
// ----------------------------------------------
module spi_status_and_data_path_tb;
  localparam [7:0] DAT = `SPISD_IDX_DATA;
  localparam [7:0] CTL = `SPISD_IDX_CTRL;
  localparam [7:0] CSR = `SPISD_IDX_CSR;
  localparam [7:0] EVS = `SPISD_IDX_EVSTAT;
  localparam [7:0] MSK = `SPISD_IDX_EVMASK;
  localparam [1:0] OK  = `SPISD_RESP_OKAY;
  localparam [1:0] ERR = `SPISD_RESP_SLVERR;
  int          n_checks = 0;
  int          n_mismatch = 0;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe;
  wire         miso_in, miso_out, miso_oe, ss_n_in, irq;
  spisd_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .sck_out,
    .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
    .ss_n_in, .irq);
  spisd_partner i_partner (.aclk, .sck_out, .sck_oe, .mosi_out, .miso_out,
    .sck_in, .mosi_in, .ss_n_in, .miso_in);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    $display("Error wait exp done got none");
    finish_test();
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input [7:0] idx, input [7:0] d, input [1:0] er);
    int n;
    begin
      n = 0;
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Ready raised late so the slave must hold its response
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        if (n > 200) timeout();
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
      @(posedge aclk);
    end
  endtask
  task automatic rdq(input [7:0] idx, output logic [7:0] q, output logic [1:0] r);
    int n;
    begin
      n = 0;
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        if (n > 200) timeout();
      end while (!(s_axi_rvalid && s_axi_rready));
      q = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task automatic rd(input [7:0] idx, input [7:0] e);
    logic [7:0] q;
    logic [1:0] r;
    begin
      rdq(idx, q, r);
      `CHK($sformatf("reg %h", idx), e, q)
      `CHK("rresp", OK, r)
    end
  endtask
  task automatic wait_irq(input logic e);
    int n;
    begin
      n = 0;
      while (irq !== e) begin
        @(posedge aclk);
        n++;
        if (n > 3000) timeout();
      end
      `CHK("irq", e, irq)
    end
  endtask
  // Main sequence: registers, master, events, slave, fault
  initial begin
    logic [7:0] q;
    logic [1:0] r;
    int n;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CTL, 8'h00);
    rd(CSR, 8'h00);
    rdq(8'h30, q, r);
    `CHK("unmapped rresp", ERR, r)
    wr(8'h30, 8'hff, ERR);
    wr(MSK, 8'h0f, OK);
    rd(MSK, 8'h0f);
    wr(MSK, 8'h00, OK);
    wr(CSR, 8'h03, OK); // bit 3 kept clear
    // Divide by 8: return data needs three edges through the synchroniser
    wr(CTL, 8'hd0, OK);
    i_partner.load(8'ha5);
    wr(DAT, 8'h3c, OK);
    wr(DAT, 8'h99, OK); // collides while shifting
    wait_irq(1'b1);
    rd(CSR, 8'hc3);
    `CHK("far rx", 8'h3c, i_partner.rx_sr)
    rd(DAT, 8'ha5);
    wait_irq(1'b0);
    rd(CSR, 8'h03);
    i_partner.load(8'h6e);
    wr(DAT, 8'h5a, OK);
    wait_irq(1'b1);
    wr(DAT, 8'h11, OK); // must be dropped
    rd(CSR, 8'h83);
    rd(DAT, 8'h6e);
    `CHK("far rx", 8'h5a, i_partner.rx_sr)
    rd(EVS, 8'h03);
    rd(EVS, 8'h00);
    wr(CTL, 8'h70, OK);
    wr(DAT, 8'h42, OK);
    n = 0;
    q = 8'h00;
    while (!q[7]) begin
      rdq(CSR, q, r);
      n++;
      if (n > 100) timeout();
    end
    `CHK("masked irq", 1'b0, irq)
    wr(MSK, 8'h01, OK);
    wait_irq(1'b1);
    rd(EVS, 8'h01);
    wait_irq(1'b0);
    rdq(DAT, q, r);
    wr(MSK, 8'h00, OK);
    wr(CTL, 8'h00, OK);
    wr(CSR, 8'h02, OK); // selected by software
    wr(CTL, 8'hc0, OK);
    wr(DAT, 8'h69, OK);
    i_partner.send(8'h96, 1'b0, q); // pin high
    `CHK("far rx", 8'h69, q)
    wait_irq(1'b1);
    rd(CSR, 8'h82);
    rd(DAT, 8'h96);
    wr(CSR, 8'h03, OK);
    i_partner.send(8'h55, 1'b1, q); // pin low but ignored
    rd(CSR, 8'h03);
    wr(CSR, 8'h02, OK);
    i_partner.send(8'h11, 1'b0, q);
    i_partner.send(8'h22, 1'b0, q);
    rd(CSR, 8'ha2);
    rd(DAT, 8'h11);
    rd(CSR, 8'h02);
    wr(CSR, 8'h06, OK);
    `CHK("miso_oe", 1'b0, miso_oe)
    wr(CSR, 8'h02, OK);
    `CHK("miso_oe", 1'b1, miso_oe)
    wr(CTL, 8'h00, OK);
    `CHK("miso_oe", 1'b0, miso_oe)
    wr(CSR, 8'h00, OK);
    wr(CTL, 8'hd0, OK);
    `CHK("sck_oe", 1'b1, sck_oe)
    `CHK("mosi_oe", 1'b1, mosi_oe)
    i_partner.pin(1'b0);
    wait_irq(1'b1);
    rd(CTL, 8'h80);
    rd(CSR, 8'h10);
    i_partner.pin(1'b1);
    wr(CTL, 8'h80, OK);
    rd(CSR, 8'h00);
    wait_irq(1'b0);
    // Clock pin idles at the programmed polarity
    wr(CTL, 8'h08, OK);
    `CHK("sck_out", 1'b1, sck_out)
    finish_test();
  end
endmodule
